// File: verilog/cc_err_check.sv
// control channel error checking, fault injection and alias remap
`include "cc_err_regs.svh"
`default_nettype none
module cc_err_check #(
  parameter int ADDR_W = 10
) (
  // clock and reset
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  // axi4-lite register slave
  input  wire logic                 s_awvalid,
  output logic                      s_awready,
  input  wire logic [ADDR_W-1:0]    s_awaddr,
  input  wire logic                 s_wvalid,
  output logic                      s_wready,
  input  wire logic [31:0]          s_wdata,
  input  wire logic [3:0]           s_wstrb,
  output logic                      s_bvalid,
  input  wire logic                 s_bready,
  output logic [1:0]                s_bresp,
  input  wire logic                 s_arvalid,
  output logic                      s_arready,
  input  wire logic [ADDR_W-1:0]    s_araddr,
  output logic                      s_rvalid,
  input  wire logic                 s_rready,
  output logic [31:0]               s_rdata,
  output logic [1:0]                s_rresp,
  // forward bytes in from the local i2c side and out to the link
  input  wire logic                 fwd_in_valid,
  input  wire cc_err_pkg::fwd_frame_t fwd_in,
  output logic                      fwd_out_valid,
  output cc_err_pkg::fwd_frame_t    fwd_out,
  // acknowledges back from the partner and out to the local host
  input  wire logic                 ack_in_valid,
  input  wire cc_err_pkg::ack_info_t ack_in,
  output logic                      ack_out_valid,
  output logic                      ack_out,
  output logic                      terminate,
  // remote read start
  input  wire logic                 rd_start,
  output logic                      rd_self_ack,
  // alias remap: hit is 0 none, 1 slot one, 2 slot two
  input  wire logic                 addr_in_valid,
  input  wire logic [6:0]           addr_in,
  input  wire logic [1:0]           alias_hit,
  output logic                      addr_out_valid,
  output logic [6:0]                addr_out,
  // interrupt
  output logic                      irq
);
  import cc_err_pkg::*;

  // mask for one flipped data bit; random pick spreads over bits 1..7
  function automatic logic [7:0] flip_mask(input err_type_t t, input logic [2:0] rnd);
    logic [7:0] m;
    m = 8'h00;
    case (t)
      ERR_DATA_RND: m = 8'h01 << ((rnd == 3'd0) ? 3'd1 : rnd);
      ERR_DATA_B0:  m = 8'h01;
      default:      m = 8'h00;
    endcase
    return m;
  endfunction

  // register index from a byte address, word aligned
  function automatic logic [7:0] reg_idx(input logic [ADDR_W-1:0] a);
    return a[9:2];
  endfunction

  // ---------------- register and bus state ----------------
  logic [7:0]        cfg_q, cfg_d;            // error config
  logic [7:0]        fi_q, fi_d;              // fault injection, force bit never stored
  logic [7:0]        ra1_q, ra1_d;            // remote address slot 1
  logic [7:0]        ra2_q, ra2_d;            // remote address slot 2
  logic [7:0]        sts_q, sts_d;            // sticky events
  logic [7:0]        msk_q, msk_d;            // event mask
  logic              aw_have_q, aw_have_d;    // write address held
  logic              w_have_q, w_have_d;      // write data held
  logic [ADDR_W-1:0] awaddr_q, awaddr_d;
  logic [31:0]       wdata_q, wdata_d;
  logic              wstrb0_q, wstrb0_d;
  logic              bvalid_q, bvalid_d;
  logic [1:0]        bresp_q, bresp_d;
  logic              rvalid_q, rvalid_d;
  logic [31:0]       rdata_q, rdata_d;
  logic [1:0]        rresp_q, rresp_d;
  logic              irq_q, irq_d;
  logic              force_wr;                // pulse: force bit written as one
  logic [7:0]        ev;                      // events raised by the datapath this cycle

  // bus slave, register writes and reads
  always_comb begin
    logic [7:0] widx;
    logic [7:0] ridx;
    logic       wr;
    widx       = reg_idx(awaddr_q);
    ridx       = reg_idx(s_araddr);
    wr         = aw_have_q && w_have_q && !bvalid_q;
    cfg_d      = cfg_q;
    fi_d       = fi_q;
    ra1_d      = ra1_q;
    ra2_d      = ra2_q;
    msk_d      = msk_q;
    force_wr   = 1'b0;
    aw_have_d  = aw_have_q;
    w_have_d   = w_have_q;
    awaddr_d   = awaddr_q;
    wdata_d    = wdata_q;
    wstrb0_d   = wstrb0_q;
    bvalid_d   = bvalid_q;
    bresp_d    = bresp_q;
    rvalid_d   = rvalid_q;
    rdata_d    = rdata_q;
    rresp_d    = rresp_q;
    // capture address and data in either order
    if (s_awvalid && !aw_have_q) begin
      aw_have_d = 1'b1;
      awaddr_d  = s_awaddr;
    end
    if (s_wvalid && !w_have_q) begin
      w_have_d = 1'b1;
      wdata_d  = s_wdata;
      wstrb0_d = s_wstrb[0];
    end
    // sticky bits: a new event wins over a same-cycle clear
    sts_d = sts_q;
    if (wr && wstrb0_q && widx == `IDX_IRQ_STATUS) begin
      sts_d = sts_q & ~wdata_q[7:0];
    end
    sts_d = (sts_d | ev) & `IRQ_WMASK;
    // commit a write once both halves are here
    if (wr) begin
      aw_have_d = 1'b0;
      w_have_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = `RESP_OKAY;
      case (widx)
        `IDX_ERR_CONFIG: begin
          if (wstrb0_q) cfg_d = (wdata_q[7:0] & `CFG_WMASK);
        end
        `IDX_FAULT_INJECT: begin
          if (wstrb0_q) begin
            fi_d     = wdata_q[7:0] & `FI_WMASK;
            force_wr = wdata_q[`FI_FORCE_BIT];
          end
        end
        `IDX_REMOTE_ADDR_1: begin
          if (wstrb0_q) ra1_d = wdata_q[7:0] & `RA_WMASK;
        end
        `IDX_REMOTE_ADDR_2: begin
          if (wstrb0_q) ra2_d = wdata_q[7:0] & `RA_WMASK;
        end
        `IDX_IRQ_STATUS: begin
          bresp_d = `RESP_OKAY;
        end
        `IDX_IRQ_MASK: begin
          if (wstrb0_q) msk_d = wdata_q[7:0] & `IRQ_WMASK;
        end
        default: bresp_d = `RESP_DECERR;
      endcase
    end
    if (bvalid_q && s_bready) bvalid_d = 1'b0;
    // reads answer one cycle after they are taken
    if (s_arvalid && !rvalid_q) begin
      rvalid_d = 1'b1;
      rresp_d  = `RESP_OKAY;
      rdata_d  = 32'h0000_0000;
      case (ridx)
        `IDX_ERR_CONFIG:    rdata_d[7:0] = cfg_q;
        `IDX_FAULT_INJECT:  rdata_d[7:0] = fi_q;            // force bit reads zero
        `IDX_REMOTE_ADDR_1: rdata_d[7:0] = ra1_q;
        `IDX_REMOTE_ADDR_2: rdata_d[7:0] = ra2_q;
        `IDX_IRQ_STATUS:    rdata_d[7:0] = sts_q;
        `IDX_IRQ_MASK:      rdata_d[7:0] = msk_q;
        default:            rresp_d      = `RESP_DECERR;
      endcase
    end else if (rvalid_q && s_rready) begin
      rvalid_d = 1'b0;
    end
    irq_d = |(sts_d & msk_d);
  end

  // register the bus and register state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_q     <= `CFG_RST;
      fi_q      <= `FI_RST;
      ra1_q     <= `RA_RST;
      ra2_q     <= `RA_RST;
      sts_q     <= 8'h00;
      msk_q     <= 8'h00;
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= 32'h0000_0000;
      wstrb0_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `RESP_OKAY;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= `RESP_OKAY;
      irq_q     <= 1'b0;
    end else begin
      cfg_q     <= cfg_d;
      fi_q      <= fi_d;
      ra1_q     <= ra1_d;
      ra2_q     <= ra2_d;
      sts_q     <= sts_d;
      msk_q     <= msk_d;
      aw_have_q <= aw_have_d;
      w_have_q  <= w_have_d;
      awaddr_q  <= awaddr_d;
      wdata_q   <= wdata_d;
      wstrb0_q  <= wstrb0_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      rvalid_q  <= rvalid_d;
      rdata_q   <= rdata_d;
      rresp_q   <= rresp_d;
      irq_q     <= irq_d;
    end
  end

  // ---------------- forward path with fault injection ----------------
  logic       pend_q, pend_d;          // armed, waiting for next transfer start
  logic       act_q, act_d;            // armed inside the current transfer
  logic [2:0] cnt_q, cnt_d;            // byte number within transfer
  logic       past8_q, past8_d;        // beyond the first eight bytes
  logic [2:0] rnd_q, rnd_d;            // pseudo random bit pick
  logic       fvalid_q, fvalid_d;
  fwd_frame_t fout_q, fout_d;
  logic [7:0] sent_q, sent_d;          // last byte sent, for echo compare
  logic       inj_ev;

  // pick the byte and corrupt it once
  always_comb begin
    err_type_t  et;
    logic       s;
    logic [2:0] n;
    logic       p8;
    et       = err_type_t'(fi_q[`FI_TYPE_HI:`FI_TYPE_LO]);
    s        = 1'b0;                                       // no byte, no start
    n        = 3'd0;
    p8       = 1'b0;
    pend_d   = pend_q | force_wr;
    act_d    = act_q;
    cnt_d    = cnt_q;
    past8_d  = past8_q;
    rnd_d    = {rnd_q[1:0], rnd_q[2] ^ rnd_q[1]};
    fvalid_d = 1'b0;
    fout_d   = fout_q;
    sent_d   = sent_q;
    inj_ev   = 1'b0;
    if (fwd_in_valid) begin
      s  = fwd_in.start;
      n  = s ? 3'd0 : cnt_q;
      p8 = s ? 1'b0 : past8_q;
      // arming moves to the transfer that starts after the write
      if (s) begin
        act_d  = pend_q;
        pend_d = force_wr;
      end
      fvalid_d = 1'b1;
      fout_d   = fwd_in;
      fout_d.bad_crc  = 1'b0;
      fout_d.skip_seq = 1'b0;
      if ((s ? pend_q : act_q) && !p8 && n == fi_q[`FI_IDX_HI:`FI_IDX_LO]) begin
        act_d  = 1'b0;
        inj_ev = 1'b1;
        case (et)
          ERR_CRC:      fout_d.bad_crc  = 1'b1;
          ERR_SEQ:      fout_d.skip_seq = 1'b1;
          ERR_DROP:     fvalid_d        = 1'b0;
          ERR_DATA_RND,
          ERR_DATA_B0:  fout_d.data     = fwd_in.data ^ flip_mask(et, rnd_q);
          default:      inj_ev          = 1'b0;
        endcase
      end
      sent_d  = fwd_in.data;
      cnt_d   = n + 3'd1;
      past8_d = p8 | (n == 3'd7);
    end
  end

  // register the forward path
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pend_q   <= 1'b0;
      act_q    <= 1'b0;
      cnt_q    <= 3'd0;
      past8_q  <= 1'b0;
      rnd_q    <= 3'b001;
      fvalid_q <= 1'b0;
      fout_q   <= '0;
      sent_q   <= 8'h00;
    end else begin
      pend_q   <= pend_d;
      act_q    <= act_d;
      cnt_q    <= cnt_d;
      past8_q  <= past8_d;
      rnd_q    <= rnd_d;
      fvalid_q <= fvalid_d;
      fout_q   <= fout_d;
      sent_q   <= sent_d;
    end
  end

  // ---------------- acknowledge checks, self ack, remap ----------------
  logic       avalid_q, avalid_d;
  logic       ack_q, ack_d;
  logic       term_q, term_d;
  logic       sack_q, sack_d;
  logic       rvld_q, rvld_d;
  logic [6:0] raddr_q, raddr_d;
  logic       mism;

  // compare the echo, override the ack, decide termination, remap
  always_comb begin
    logic enh;
    enh  = cfg_q[`CFG_ENH_EN_BIT];
    mism = ack_in_valid && cfg_q[`CFG_DATA_CHK_BIT] && (ack_in.echo != sent_q);
    avalid_d = ack_in_valid;
    ack_d    = ack_in.ack && !mism;
    term_d   = ack_in_valid && enh &&
               (mism || (ack_in.crc_err && cfg_q[`CFG_TERM_CRC_BIT]));
    sack_d   = rd_start && cfg_q[`CFG_SELF_ACK_BIT];
    rvld_d   = addr_in_valid;
    case (alias_hit)
      2'd1:    raddr_d = ra1_q[7:1];
      2'd2:    raddr_d = ra2_q[7:1];
      default: raddr_d = addr_in;
    endcase
  end

  // register the acknowledge side
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      avalid_q <= 1'b0;
      ack_q    <= 1'b0;
      term_q   <= 1'b0;
      sack_q   <= 1'b0;
      rvld_q   <= 1'b0;
      raddr_q  <= 7'd0;
    end else begin
      avalid_q <= avalid_d;
      ack_q    <= ack_d;
      term_q   <= term_d;
      sack_q   <= sack_d;
      rvld_q   <= rvld_d;
      raddr_q  <= raddr_d;
    end
  end

  // events feeding the sticky status
  assign ev = {5'b0_0000, inj_ev, term_d, mism};

  // outputs, all from flops
  assign s_awready      = !aw_have_q;
  assign s_wready       = !w_have_q;
  assign s_bvalid       = bvalid_q;
  assign s_bresp        = bresp_q;
  assign s_arready      = !rvalid_q;
  assign s_rvalid       = rvalid_q;
  assign s_rdata        = rdata_q;
  assign s_rresp        = rresp_q;
  assign fwd_out_valid  = fvalid_q;
  assign fwd_out        = fout_q;
  assign ack_out_valid  = avalid_q;
  assign ack_out        = ack_q;
  assign terminate      = term_q;
  assign rd_self_ack    = sack_q;
  assign addr_out_valid = rvld_q;
  assign addr_out       = raddr_q;
  assign irq            = irq_q;
endmodule // cc_err_check
`default_nettype wire

// File: include/cc_err_regs.svh
// register indices, field positions, reset values and bus constants
`ifndef CC_ERR_REGS_SVH
`define CC_ERR_REGS_SVH
// register indices; byte address is four times the index
`define IDX_ERR_CONFIG     8'h6E
`define IDX_FAULT_INJECT   8'h6F
`define IDX_REMOTE_ADDR_1  8'h70
`define IDX_REMOTE_ADDR_2  8'h71
`define IDX_IRQ_STATUS     8'h7E
`define IDX_IRQ_MASK       8'h7F
// config fields
`define CFG_ENH_EN_BIT     0
`define CFG_DATA_CHK_BIT   1
`define CFG_SELF_ACK_BIT   2
`define CFG_TERM_CRC_BIT   4
`define CFG_RST            8'h20
`define CFG_WMASK          8'h37
// fault injection fields
`define FI_FORCE_BIT       6
`define FI_TYPE_HI         5
`define FI_TYPE_LO         3
`define FI_IDX_HI          2
`define FI_IDX_LO          0
`define FI_RST             8'h00
`define FI_WMASK           8'h3F
// remote address fields
`define RA_RST             8'h00
`define RA_WMASK           8'hFE
// interrupt status bits
`define IRQ_MISMATCH_BIT   0
`define IRQ_TERM_BIT       1
`define IRQ_INJECT_BIT     2
`define IRQ_WMASK          8'h07
// bus answers
`define RESP_OKAY          2'b00
`define RESP_DECERR        2'b11
`endif

// File: include/cc_err_pkg.sv
// types shared by the control channel error block and its bench
package cc_err_pkg;
  // error kinds that can be injected into a forward frame
  typedef enum logic [2:0] {
    ERR_NONE, ERR_CRC, ERR_SEQ, ERR_DROP, ERR_DATA_RND, ERR_DATA_B0, ERR_RSV6, ERR_RSV7
  } err_type_t;
  // one forward control channel byte
  typedef struct packed {
    logic       start;     // first byte of a transfer
    logic [7:0] data;
    logic       bad_crc;   // transmitter must corrupt the crc
    logic       skip_seq;  // transmitter must skip one sequence number
  } fwd_frame_t;
  // one acknowledge returned over the back channel
  typedef struct packed {
    logic [7:0] echo;      // data the partner echoed back
    logic       ack;       // 1 ack, 0 nack
    logic       crc_err;   // back channel crc error seen
  } ack_info_t;
endpackage

// File: dv/cc_err_check_checker.sv
// port assertions for the control channel error block
`default_nettype none
module cc_err_check_checker (
  // clock and reset
  input wire logic                   aclk,
  input wire logic                   aresetn,
  // forward path
  input wire logic                   fwd_in_valid,
  input wire cc_err_pkg::fwd_frame_t fwd_in,
  input wire logic                   fwd_out_valid,
  input wire cc_err_pkg::fwd_frame_t fwd_out,
  // acknowledge path
  input wire logic                   ack_in_valid,
  input wire cc_err_pkg::ack_info_t  ack_in,
  input wire logic                   ack_out_valid,
  input wire logic                   ack_out,
  input wire logic                   terminate,
  // self ack and alias remap
  input wire logic                   rd_start,
  input wire logic                   rd_self_ack,
  input wire logic                   addr_in_valid,
  input wire logic [6:0]             addr_in,
  input wire logic [1:0]             alias_hit,
  input wire logic                   addr_out_valid,
  input wire logic [6:0]             addr_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import cc_err_pkg::*;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // a byte taken and its registered copy one cycle later
  sequence s_fwd_take;
    fwd_in_valid ##1 fwd_out_valid;
  endsequence
  // an acknowledge taken and passed on one cycle later
  sequence s_ack_take;
    ack_in_valid ##1 ack_out_valid;
  endsequence
  a_self_ack_cause:
    assert property (rd_self_ack |-> $past(rd_start))
      else $error("self ack without a read start");
  a_ack_source:
    assert property (ack_out_valid |-> $past(ack_in_valid))
      else $error("ack out without ack in");
  a_ack_follows:
    assert property (ack_in_valid |-> s_ack_take)
      else $error("ack not passed on next cycle");
  a_nack_kept:
    assert property (ack_in_valid && !ack_in.ack |=> ack_out_valid && !ack_out)
      else $error("remote nack turned into ack");
  a_term_on_ack:
    assert property (terminate |-> ack_out_valid)
      else $error("terminate outside an ack");
  a_fwd_source:
    assert property (fwd_out_valid |-> $past(fwd_in_valid))
      else $error("forward byte from nowhere");
  a_start_kept:
    assert property (s_fwd_take |-> fwd_out.start == $past(fwd_in.start))
      else $error("start marker altered");
  a_remap_pass:
    assert property (addr_in_valid && (alias_hit == 2'd0 || alias_hit == 2'd3)
      |=> addr_out_valid && addr_out == $past(addr_in))
      else $error("address without alias hit changed");
endmodule // cc_err_check_checker
bind cc_err_check cc_err_check_checker i_cc_err_check_checker (.*);
`default_nettype wire

// File: dv/cc_err_partner.sv
// far-side partner: echoes each forward byte back as an acknowledge
`default_nettype none
module cc_err_partner (
  // clock and reset
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  // forward bytes from the block
  input  wire logic                   fwd_out_valid,
  input  wire cc_err_pkg::fwd_frame_t fwd_out,
  // bit0 corrupts the echo, bit1 answers nack; slow adds two cycles
  input  wire logic [1:0]             p_cmd,
  input  wire logic                   p_slow,
  // acknowledges back to the block
  output logic                        ack_in_valid,
  output cc_err_pkg::ack_info_t       ack_in
);
  timeunit 1ns;
  timeprecision 1ps;
  import cc_err_pkg::*;
  logic [2:0] v_q;     // answer pipeline
  logic [2:0] c_q;     // crc fault seen per stage
  logic [7:0] d_q [3]; // byte per stage
  logic [7:0] e;       // byte of the answering stage
  // pipeline keeps back to back bytes apart
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      v_q <= '0;
      c_q <= '0;
      d_q <= '{8'h00, 8'h00, 8'h00};
    end else begin
      v_q <= {v_q[1:0], fwd_out_valid};
      c_q <= {c_q[1:0], fwd_out.bad_crc};
      d_q <= '{fwd_out.data, d_q[0], d_q[1]};
    end
  end
  assign e = p_slow ? d_q[2] : d_q[0];
  assign ack_in_valid = p_slow ? v_q[2] : v_q[0];
  // idle lines carry the inverse so a stale echo never matches
  assign ack_in = ack_in_valid ? ack_info_t'{e ^ {7'h0, p_cmd[0]}, !p_cmd[1],
    p_slow ? c_q[2] : c_q[0]} : ack_info_t'{~e, 1'b0, 1'b0};
endmodule // cc_err_partner
`default_nettype wire

// File: dv/cc_err_check_tb.sv
// self-checking bench for the control channel error block
`include "cc_err_regs.svh"
`default_nettype none
module cc_err_check_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import cc_err_pkg::*;
  logic aclk = 0, aresetn = 0, s_awvalid = 0, s_wvalid = 0, s_bready = 0;
  logic s_arvalid = 0, s_rready = 0, fwd_in_valid = 0, rd_start = 0, addr_in_valid = 0;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, fwd_out_valid, ack_in_valid;
  logic ack_out_valid, ack_out, terminate, rd_self_ack, addr_out_valid, irq, p_slow = 0;
  logic [9:0] s_awaddr = '0, s_araddr = '0;
  logic [31:0] s_wdata = '0, s_rdata;
  logic [3:0] s_wstrb = '0;
  logic [1:0] s_bresp, s_rresp, alias_hit = '0, p_cmd = '0;
  logic [6:0] addr_in = '0, addr_out;
  fwd_frame_t fwd_in = '0, fwd_out, q[$];
  ack_info_t ack_in;
  logic [7:0] sent [8], v, a1, a2, b;
  logic [7:0] ix [5] = '{`IDX_ERR_CONFIG, `IDX_FAULT_INJECT, `IDX_REMOTE_ADDR_1,
    `IDX_REMOTE_ADDR_2, `IDX_IRQ_MASK};
  logic a_v, t_v, mis;
  int miscompares = 0, cmp_count = 0, cyc = 0, a_cnt = 0, t_cnt = 0;
  cc_err_check i_cc_err_check (.*);
  cc_err_partner i_cc_err_partner (.*);
  initial forever #4 aclk = ~aclk;
  // monitors sample before the edge lands; hang guard
  always @(posedge aclk) begin
    cyc++;
    if (fwd_out_valid) q.push_back(fwd_out);
    if (ack_out_valid) begin
      a_cnt++;
      a_v = ack_out;
      t_v = terminate;
    end
    if (terminate === 1'b1) t_cnt++;
    if (cyc == 6000) begin
      miscompares++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // bus write: hold each channel until taken, bready until the answer
  task automatic wr(input logic [7:0] i, input logic [7:0] d, input logic [1:0] r = `RESP_OKAY);
    @(posedge aclk);
    s_awvalid <= 1;
    s_awaddr <= {i, 2'b00};
    s_wvalid <= 1;
    s_wdata <= {24'h0, d};
    s_wstrb <= 4'h1;
    s_bready <= 1;
    do begin
      @(posedge aclk);
      if (s_awready) s_awvalid <= 0;
      if (s_wready) s_wvalid <= 0;
    end while (s_bvalid !== 1'b1);
    s_bready <= 0;
    chk(s_bresp, r, "bresp");
  endtask
  task automatic rd(input logic [7:0] i, input logic [7:0] e, input logic [1:0] r = `RESP_OKAY);
    @(posedge aclk);
    s_arvalid <= 1;
    s_araddr <= {i, 2'b00};
    s_rready <= 1;
    do begin
      @(posedge aclk);
      if (s_arready) s_arvalid <= 0;
    end while (s_rvalid !== 1'b1);
    s_rready <= 0;
    chk(s_rresp, r, "rresp");
    chk(s_rdata, {24'h0, e}, "rdata");
  endtask
  function automatic logic [7:0] wmask(input logic [7:0] i);
    case (i)
      `IDX_ERR_CONFIG: return `CFG_WMASK;
      `IDX_FAULT_INJECT: return `FI_WMASK;
      `IDX_IRQ_MASK: return `IRQ_WMASK;
      default: return `RA_WMASK;
    endcase
  endfunction
  // expected data difference; a random flip must hit one of bits 7..1
  function automatic logic [7:0] flip(input logic [2:0] ty, input logic hit, input logic [7:0] x);
    if (hit && ty == ERR_DATA_B0) return 8'h01;
    if (hit && ty == ERR_DATA_RND) return ($onehot(x) && !x[0]) ? x : ~x;
    return 8'h00;
  endfunction
  // back to back transfer; input crc and sequence flags must be ignored
  task automatic send(input int n);
    for (int i = 0; i < n; i++) begin
      sent[i] = 8'($urandom);
      @(posedge aclk);
      fwd_in_valid <= 1;
      fwd_in <= '{i == 0, sent[i], 1'($urandom), 1'($urandom)};
    end
    @(posedge aclk);
    fwd_in_valid <= 0;
    repeat (8) @(posedge aclk);
  endtask
  task automatic chk_xfer(input logic [2:0] ty, input int bi);
    int k = 0;
    logic [7:0] x;
    for (int i = 0; i < 8; i++) begin
      if (ty == ERR_DROP && i == bi) continue;
      x = q[k].data ^ sent[i];
      chk({q[k].start, q[k].bad_crc, q[k].skip_seq},
        {i == 0, i == bi && ty == ERR_CRC, i == bi && ty == ERR_SEQ}, "flags");
      chk(x, flip(ty, i == bi, x), "data");
      k++;
    end
    chk(q.size(), k, "count");
    q.delete();
  endtask
  initial begin
    void'($urandom(32'he3bd));
    repeat (5) @(posedge aclk);
    aresetn <= 1;
    for (int i = 0; i < 5; i++) rd(ix[i], i == 0 ? `CFG_RST : 8'h00);
    for (int i = 0; i < 5; i++) begin
      v = 8'($urandom) & 8'hBF;
      wr(ix[i], v);
      rd(ix[i], v & wmask(ix[i]));
    end
    wr(8'h50, 8'hAA, `RESP_DECERR);
    rd(8'h50, 8'h00, `RESP_DECERR);
    $display("test registers done");
    wr(`IDX_ERR_CONFIG, 8'h30);
    for (int t = 0; t < 8; t++) begin
      b = (t == 2) ? 8'd7 : 8'($urandom % 8);
      wr(`IDX_FAULT_INJECT, {2'b01, t[2:0], b[2:0]});
      q.delete();
      send(8);
      chk_xfer(t[2:0], b);
      rd(`IDX_FAULT_INJECT, {2'b00, t[2:0], b[2:0]});
      rd(`IDX_IRQ_STATUS, {5'h0, t inside {[1:5]}, 2'b00});
      wr(`IDX_IRQ_STATUS, 8'h07);
      send(8);
      chk_xfer(t[2:0], 8);
    end
    chk(t_cnt, 0, "terminate");
    // crc fault on byte 0 with enhanced checking on must terminate once
    wr(`IDX_ERR_CONFIG, 8'h31);
    wr(`IDX_FAULT_INJECT, 8'h48);
    t_cnt = 0;
    send(1);
    chk(t_cnt, 1, "crc terminate");
    rd(`IDX_IRQ_STATUS, 8'h06);
    wr(`IDX_IRQ_STATUS, 8'h07);
    $display("test injection done");
    wr(`IDX_IRQ_MASK, 8'h01);
    for (int c = 0; c < 16; c++) begin
      wr(`IDX_ERR_CONFIG, {3'b001, 1'($urandom), 2'b00, c[1:0]});
      p_cmd <= c[3:2];
      p_slow <= 1'($urandom);
      a_cnt = 0;
      mis = c[1] & c[2];
      send(1);
      chk({a_cnt[29:0], a_v, t_v}, {30'd1, !c[3] && !mis, c[0] && mis}, "ack");
      chk(irq, mis, "irq");
      rd(`IDX_IRQ_STATUS, {6'h0, c[0] && mis, mis});
      wr(`IDX_IRQ_STATUS, 8'h07);
      rd(`IDX_IRQ_STATUS, 8'h00);
      chk(irq, 0, "irq clear");
    end
    $display("test acknowledge done");
    for (int c = 0; c < 2; c++) begin
      wr(`IDX_ERR_CONFIG, {5'b00100, c[0], 2'b00});
      @(posedge aclk);
      rd_start <= 1;
      @(posedge aclk);
      rd_start <= 0;
      @(posedge aclk);
      chk(rd_self_ack, c[0], "self ack");
    end
    a1 = 8'($urandom);
    a2 = 8'($urandom);
    wr(`IDX_REMOTE_ADDR_1, a1);
    wr(`IDX_REMOTE_ADDR_2, a2);
    for (int h = 0; h < 4; h++) begin
      @(posedge aclk);
      addr_in_valid <= 1;
      addr_in <= 7'($urandom);
      alias_hit <= h[1:0];
      @(posedge aclk);
      addr_in_valid <= 0;
      @(posedge aclk);
      chk({addr_out_valid, addr_out},
        {1'b1, h == 1 ? a1[7:1] : h == 2 ? a2[7:1] : addr_in}, "remap");
    end
    $display("test self ack and remap done");
    give_verdict();
  end
endmodule // cc_err_check_tb
`default_nettype wire
